// ===== logic/eic_pkg.sv
// Constants for the external-control decoder and cycle-cost sequencer.
// Assumes a single 125 MHz clock and a 16-bit instruction word, bit 0 = MSB.
package eic_pkg;
  // ---------------------------------------------
  // Opcode fields (bits 0..10 of the word; bits 0..5 for the 6-bit ones)
  // ---------------------------------------------
  localparam logic [10:0] OP_IDLE = 11'h01A;
  localparam logic [10:0] OP_MASK_CLEAR = 11'h01B;
  localparam logic [10:0] OP_USER_HHL = 11'h01E;
  localparam logic [10:0] OP_USER_HLH = 11'h01D;
  localparam logic [10:0] OP_USER_HHH = 11'h01F;
  localparam logic [10:0] OP_MASK_LOAD = 11'h018;
  localparam logic [5:0] OP_DIV_TOP = 6'h0F;
  localparam logic [5:0] OP_XOP_TOP = 6'h0B;
  localparam logic [5:0] OP_EXEC_IND = 6'h12;
  // ---------------------------------------------
  // Address-line codes, A0 first
  // ---------------------------------------------
  localparam logic [2:0] CODE_IDLE = 3'h2;
  localparam logic [2:0] CODE_MASK_CLEAR = 3'h3;
  localparam logic [2:0] CODE_USER_HHL = 3'h6;
  localparam logic [2:0] CODE_USER_HLH = 3'h5;
  localparam logic [2:0] CODE_USER_HHH = 3'h7;
  // ---------------------------------------------
  // Status field positions and reset
  // ---------------------------------------------
  localparam int MASK_LSB = 0;
  localparam int MASK_W = 4;
  localparam logic [15:0] ST_RESET = 16'h0000;
  localparam int ST_OVF_BIT = 11;
  // ---------------------------------------------
  // Cycle and access costs
  // ---------------------------------------------
  localparam logic [7:0] C_EXT = 8'h0C;
  localparam logic [3:0] M_EXT = 4'h1;
  localparam logic [7:0] C_RESET = 8'h1A;
  localparam logic [3:0] M_RESET = 4'h5;
  localparam logic [7:0] C_CTX = 8'h16;
  localparam logic [3:0] M_CTX = 4'h5;
  localparam logic [7:0] C_UNDEF = 8'h06;
  localparam logic [3:0] M_UNDEF = 4'h1;
  localparam logic [7:0] C_MASK_LOAD = 8'h0E;
  localparam logic [3:0] M_MASK_LOAD = 4'h2;
  localparam logic [7:0] C_DIV_OVF = 8'h10;
  localparam logic [7:0] C_DIV_MIN = 8'h5C;
  localparam logic [7:0] C_DIV_MAX = 8'h7C;
  localparam logic [3:0] M_DIV_OVF = 4'h3;
  localparam logic [3:0] M_DIV = 4'h6;
  localparam logic [7:0] C_EXEC_IND = 8'h08;
  localparam logic [3:0] M_EXEC_IND = 4'h2;
  localparam logic [7:0] C_EXEC_REBATE = 8'h04;
  localparam logic [3:0] M_EXEC_REBATE = 4'h1;
  // Kind of cost table applied to an operand
  typedef enum logic [1:0] {
    EIC_TBL_NONE = 2'h0,
    EIC_TBL_A = 2'h1,
    EIC_TBL_B = 2'h2
  } eic_tbl_t;
endpackage

// ===== logic/eic_cost_if.sv
// Cost request and answer between sequencer and cost calculator.
// Assumes both ends on the same clock; combinational answer.
interface eic_cost_if;
  import eic_pkg::*;
  logic [7:0] base_c;
  logic [3:0] base_m;
  eic_tbl_t tbl_s;
  eic_tbl_t tbl_d;
  logic [1:0] ts;
  logic [3:0] s;
  logic [1:0] td;
  logic [3:0] d;
  logic [3:0] wait_st;
  logic [7:0] rebate_c;
  logic [3:0] rebate_m;
  logic [7:0] tot_c;
  logic [3:0] tot_m;
  logic [11:0] total;
  modport req (output base_c, base_m, tbl_s, tbl_d, ts, s, td, d, wait_st, rebate_c,
    rebate_m, input tot_c, tot_m, total);
  modport calc (input base_c, base_m, tbl_s, tbl_d, ts, s, td, d, wait_st, rebate_c,
    rebate_m, output tot_c, tot_m, total);
endinterface

// ===== logic/eic_cost.sv
// Cycle and access cost: base plus per-operand modification, T = C + W*M.
// Assumes inputs stable for the cycle in which the answer is taken.
module eic_cost
  import eic_pkg::*;
(
  eic_cost_if.calc cif
);
  // Extra cycles for one operand
  function automatic logic [7:0] mod_c(input eic_tbl_t t, input logic [1:0] ty,
                                      input logic [3:0] r);
    mod_c = 8'h00;
    if (t != EIC_TBL_NONE) begin
      unique case (ty)
        2'h0: mod_c = 8'h00;
        2'h1: mod_c = 8'h04;
        2'h3: mod_c = (t == EIC_TBL_A) ? 8'h08 : 8'h06;
        2'h2: mod_c = 8'h08;
      endcase
    end
  endfunction
  // Extra accesses for one operand
  function automatic logic [3:0] mod_m(input eic_tbl_t t, input logic [1:0] ty,
                                      input logic [3:0] r);
    mod_m = 4'h0;
    if (t != EIC_TBL_NONE) begin
      unique case (ty)
        2'h0: mod_m = 4'h0;
        2'h1: mod_m = 4'h1;
        2'h3: mod_m = 4'h2;
        2'h2: mod_m = (r == 4'h0) ? 4'h1 : 4'h2;
      endcase
    end
  endfunction
  logic [7:0] c_sum;
  logic [3:0] m_sum;
  always_comb begin
    // see [RULE7] see [RULE8] see [RULE10]
    c_sum = cif.base_c + mod_c(cif.tbl_s, cif.ts, cif.s) + mod_c(cif.tbl_d, cif.td, cif.d)
      - cif.rebate_c;
    m_sum = cif.base_m + mod_m(cif.tbl_s, cif.ts, cif.s) + mod_m(cif.tbl_d, cif.td, cif.d)
      - cif.rebate_m;
  end
  assign cif.tot_c = c_sum;
  assign cif.tot_m = m_sum;
  // see [RULE6]
  assign cif.total = {4'h0, c_sum} + 12'(cif.wait_st) * 12'(m_sum);
endmodule

// ===== logic/eic_top.sv
// External-control decoder and microcycle sequencer of the processor control unit.
// Assumes one instruction word offered with i_instr_valid while o_ready is high;
// interrupt, load and reset requests come from logic on the same clock.
// Functional notes
// [RULE1] External instruction drives code and strobes once
// [RULE2] Codes: idle LHL, clear LHH, user HHL/HLH/HHH
// [RULE3] Idle halts until interrupt, load or reset
// [RULE4] Mask clear zeroes status bits 12-15
// [RULE5] Cycle-end low during last clock period
// [RULE6] Time is cycles plus waits times accesses
// [RULE7] Base counts assume workspace register operands
// [RULE8] Modified operands add table cycles and accesses
// [RULE9] Divide takes 16 on overflow, else 92-124
// [RULE10] Execute-indirect adds target cost less 4,1
// [RULE11] Mask load copies immediate bits 12-15
// [RULE12] External 12/1, reset 26/5, contexts 22/5
// [RULE13] Undefined opcodes are 6-cycle no-operations
module eic_top
  import eic_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Instruction offer
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic [15:0] i_immediate,
  input wire logic i_exec_indirect,
  input wire logic [7:0] i_div_cycles,
  input wire logic i_div_overflow,
  input wire logic [3:0] i_wait_states,
  // Context requests
  input wire logic i_int_req,
  input wire logic i_load_req,
  input wire logic i_reset_req,
  // Status
  output logic o_ready,
  output logic o_idle,
  output logic [15:0] o_status,
  // External control pins
  output logic [2:0] o_upper_addr,
  output logic o_bit_io_strobe,
  output logic o_microcycle_end_n,
  // Cost of the last instruction
  output logic [7:0] o_cycles,
  output logic [3:0] o_accesses,
  output logic [11:0] o_total_time
);
  typedef enum logic [2:0] {
    EIC_READY = 3'b001,
    EIC_RUN = 3'b010,
    EIC_IDLE = 3'b100
  } eic_state_t;

  typedef struct packed {
    eic_state_t st;
    logic [11:0] cnt;
    logic [15:0] status;
    logic [2:0] addr;
    logic strobe;
    logic cyc_end_n;
    logic enter_idle;
    logic [7:0] cycles;
    logic [3:0] accesses;
    logic [11:0] total;
  } eic_regs_t;

  eic_regs_t r_reg;
  eic_regs_t r_next;
  eic_cost_if cif();

  eic_cost u_cost (
    .cif(cif)
  );

  // ---------------------------------------------
  // Decode
  // ---------------------------------------------
  logic [10:0] op11;
  logic is_ext;
  logic [2:0] ext_code;
  logic defined;
  always_comb begin
    op11 = i_instr[15:5];
    is_ext = 1'b1;
    ext_code = CODE_IDLE;
    // see [RULE2]
    unique case (op11)
      OP_IDLE: ext_code = CODE_IDLE;
      OP_MASK_CLEAR: ext_code = CODE_MASK_CLEAR;
      OP_USER_HHL: ext_code = CODE_USER_HHL;
      OP_USER_HLH: ext_code = CODE_USER_HLH;
      OP_USER_HHH: ext_code = CODE_USER_HHH;
      default: is_ext = 1'b0;
    endcase
    // see [RULE13]
    defined = !((i_instr[15:9] == 7'h00) || (i_instr[15:6] == 10'h00C && i_instr[5:0] >= 6'h20)
      || (i_instr[15:10] == 6'h03) || (i_instr[15:7] == 9'h00F));
    cif.base_c = C_UNDEF;
    cif.base_m = M_UNDEF;
    cif.tbl_s = EIC_TBL_NONE;
    cif.tbl_d = EIC_TBL_NONE;
    cif.ts = i_instr[5:4];
    cif.s = i_instr[3:0];
    cif.td = 2'h0;
    cif.d = 4'h0;
    cif.wait_st = i_wait_states;
    cif.rebate_c = 8'h00;
    cif.rebate_m = 4'h0;
    if (i_reset_req) begin
      cif.base_c = C_RESET; // see [RULE12]
      cif.base_m = M_RESET;
    end else if (i_load_req || i_int_req) begin
      cif.base_c = C_CTX; // see [RULE12]
      cif.base_m = M_CTX;
    end else if (is_ext) begin
      cif.base_c = C_EXT; // see [RULE12]
      cif.base_m = M_EXT;
    end else if (op11 == OP_MASK_LOAD) begin
      cif.base_c = C_MASK_LOAD;
      cif.base_m = M_MASK_LOAD;
    end else if (i_instr[15:10] == OP_DIV_TOP) begin
      // see [RULE9]
      cif.tbl_s = EIC_TBL_A;
      cif.base_m = i_div_overflow ? M_DIV_OVF : M_DIV;
      if (i_div_overflow) begin
        cif.base_c = C_DIV_OVF;
      end else if (i_div_cycles < C_DIV_MIN) begin
        cif.base_c = C_DIV_MIN;
      end else if (i_div_cycles > C_DIV_MAX) begin
        cif.base_c = C_DIV_MAX;
      end else begin
        cif.base_c = i_div_cycles;
      end
    end else if (i_instr[15:10] == OP_EXEC_IND) begin
      cif.tbl_s = EIC_TBL_A;
      cif.base_c = C_EXEC_IND;
      cif.base_m = M_EXEC_IND;
    end
    if (i_exec_indirect) begin
      cif.rebate_c = C_EXEC_REBATE; // see [RULE10]
      cif.rebate_m = M_EXEC_REBATE;
    end
  end

  // ---------------------------------------------
  // Sequencer
  // ---------------------------------------------
  logic wake;
  assign wake = i_int_req || i_load_req || i_reset_req;

  always_comb begin
    r_next = r_reg;
    r_next.strobe = 1'b0;
    r_next.cyc_end_n = 1'b1;
    unique case (r_reg.st)
      EIC_READY: begin
        if (i_reset_req || i_load_req || i_int_req || i_instr_valid) begin
          r_next.st = EIC_RUN;
          r_next.cnt = {4'h0, cif.tot_c} + 12'(i_wait_states) * 12'(cif.tot_m) - 12'h001;
          r_next.cycles = cif.tot_c;
          r_next.accesses = cif.tot_m;
          r_next.total = cif.total;
          r_next.enter_idle = 1'b0;
          if (i_reset_req) begin
            r_next.status = ST_RESET;
          end else if (!wake && is_ext) begin
            r_next.addr = ext_code; // see [RULE1]
            r_next.strobe = 1'b1;
            r_next.enter_idle = (op11 == OP_IDLE); // see [RULE3]
            if (op11 == OP_MASK_CLEAR) begin
              r_next.status[MASK_LSB +: MASK_W] = 4'h0; // see [RULE4]
            end
          end else if (!wake && op11 == OP_MASK_LOAD) begin
            // see [RULE11]
            r_next.status[MASK_LSB +: MASK_W] = i_immediate[MASK_LSB +: MASK_W];
          end else if (!wake && i_instr[15:10] == OP_DIV_TOP) begin
            r_next.status[ST_OVF_BIT] = i_div_overflow;
          end
          // Requests may clear status even with an undefined word offered
          if (!wake && !defined) begin
            r_next.status = r_reg.status;
          end
          if (r_next.cnt == 12'h000) begin
            r_next.cyc_end_n = 1'b0; // see [RULE5]
          end
        end
      end
      EIC_RUN: begin
        r_next.cnt = r_reg.cnt - 12'h001;
        if (r_reg.cnt == 12'h001) begin
          r_next.cyc_end_n = 1'b0; // see [RULE5]
        end
        // Last period runs with cycle-end low, ready or idle follows it
        if (r_reg.cnt == 12'h000) begin
          r_next.cnt = 12'h000;
          r_next.st = r_reg.enter_idle ? EIC_IDLE : EIC_READY;
        end
      end
      EIC_IDLE: begin
        if (wake) begin
          r_next.st = EIC_READY; // see [RULE3]
        end
      end
      default: r_next.st = EIC_READY;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      r_reg <= '{st: EIC_READY, cnt: 12'h000, status: ST_RESET, addr: 3'h0, strobe: 1'b0,
        cyc_end_n: 1'b1, enter_idle: 1'b0, cycles: 8'h00, accesses: 4'h0, total: 12'h000};
    end else begin
      r_reg <= r_next;
    end
  end

  // ---------------------------------------------
  // Outputs from flops; ready and idle decoded from the state register
  // ---------------------------------------------
  assign o_ready = (r_reg.st == EIC_READY);
  assign o_idle = (r_reg.st == EIC_IDLE);
  assign o_status = r_reg.status;
  assign o_upper_addr = r_reg.addr;
  assign o_bit_io_strobe = r_reg.strobe;
  assign o_microcycle_end_n = r_reg.cyc_end_n;
  assign o_cycles = r_reg.cycles;
  assign o_accesses = r_reg.accesses;
  assign o_total_time = r_reg.total;
endmodule

// ===== dv/eic_ext_decoder.sv
// Far-side logic that decodes the upper address code on each strobe.
// Assumes the strobe is a one-cycle pulse on the processor clock.
module eic_ext_decoder (
  // Clock
  input wire logic i_mclk,
  // Processor pins
  input wire logic [2:0] i_upper_addr,
  input wire logic i_bit_io_strobe,
  // Decoded result
  output logic [2:0] o_code,
  output logic [7:0] o_hits
);
  initial begin
    o_code = 3'h0;
    o_hits = 8'h00;
  end
  always @(posedge i_mclk) begin
    if (i_bit_io_strobe) begin
      o_code <= i_upper_addr;
      o_hits <= o_hits + 8'h01;
    end
  end
endmodule

// ===== dv/eic_top_assertions.sv
// Port checks for the external-control decoder, bound to eic_top.
// Assumes one clock and a synchronous active-low reset.
module eic_chk
  import eic_pkg::*;
(
  // Clock, reset, stimulus
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_exec_indirect,
  input wire logic [3:0] i_wait_states,
  input wire logic i_int_req,
  input wire logic i_load_req,
  input wire logic i_reset_req,
  // Design outputs
  input wire logic o_ready,
  input wire logic o_idle,
  input wire logic [15:0] o_status,
  input wire logic [2:0] o_upper_addr,
  input wire logic o_bit_io_strobe,
  input wire logic o_microcycle_end_n,
  input wire logic [7:0] o_cycles,
  input wire logic [3:0] o_accesses,
  input wire logic [11:0] o_total_time
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  chk_strobe_code: assert property (o_bit_io_strobe |->
    (o_upper_addr[1] || (o_upper_addr[2] && o_upper_addr[0])))
    else $error("strobe with unlisted code");
  chk_strobe_once: assert property (o_bit_io_strobe |=> !o_bit_io_strobe)
    else $error("strobe longer than one cycle");
  chk_strobe_busy: assert property (o_bit_io_strobe |-> !o_ready [*4])
    else $error("ready during external instruction");
  chk_ext_cost: assert property (o_bit_io_strobe && !$past(i_exec_indirect) |->
    o_cycles == C_EXT && o_accesses == M_EXT)
    else $error("external instruction cost wrong");
  chk_mask_cleared: assert property (o_bit_io_strobe &&
    o_upper_addr == CODE_MASK_CLEAR |-> o_status[3:0] == 4'h0)
    else $error("mask not cleared");
  chk_microcycle_end_n_pulse: assert property (!o_microcycle_end_n |=> o_microcycle_end_n)
    else $error("cycle end longer than one cycle");
  chk_microcycle_end_n_last: assert property (!o_microcycle_end_n |=> o_ready || o_idle)
    else $error("cycle end not in last period");
  chk_total_time: assert property ($fell(o_ready) |-> o_total_time ==
    {4'h0, o_cycles} + {8'h00, $past(i_wait_states)} * {8'h00, o_accesses})
    else $error("total time formula wrong");
  chk_idle_holds: assert property (o_idle && !i_int_req && !i_load_req &&
    !i_reset_req |=> o_idle)
    else $error("idle left without request");
endmodule

bind eic_top eic_chk u_chk (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_exec_indirect(i_exec_indirect),
  .i_wait_states(i_wait_states), .i_int_req(i_int_req), .i_load_req(i_load_req),
  .i_reset_req(i_reset_req), .o_ready(o_ready), .o_idle(o_idle), .o_status(o_status),
  .o_upper_addr(o_upper_addr), .o_bit_io_strobe(o_bit_io_strobe),
  .o_microcycle_end_n(o_microcycle_end_n), .o_cycles(o_cycles), .o_accesses(o_accesses),
  .o_total_time(o_total_time)
);

// ===== dv/test_eic_top.sv
// Self-checking bench for eic_top with the external decoder model.
// Assumes the eic_pkg constants and two wait states throughout.
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t ns: got %0h want %0h", $time, a, b); end end
module test_eic_top
  import eic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, xi = 1'b0, dov = 1'b0;
  logic irq = 1'b0, lrq = 1'b0, rrq = 1'b0;
  logic [15:0] ins = 16'h0000, imm = 16'h0000;
  logic [7:0] dcy = 8'h5C;
  logic [3:0] ws = 4'h2;
  logic rdy, idle, stb, cye_n;
  logic [15:0] st;
  logic [2:0] addr, code;
  logic [7:0] cyc, hits;
  logic [3:0] acc;
  logic [11:0] tot;
  int err_total = 0, n_checks = 0;
  eic_top dut (.i_mclk(clk), .i_rst_n(rst_n), .i_instr_valid(vld), .i_instr(ins),
    .i_immediate(imm), .i_exec_indirect(xi), .i_div_cycles(dcy), .i_div_overflow(dov),
    .i_wait_states(ws), .i_int_req(irq), .i_load_req(lrq), .i_reset_req(rrq),
    .o_ready(rdy), .o_idle(idle), .o_status(st), .o_upper_addr(addr),
    .o_bit_io_strobe(stb), .o_microcycle_end_n(cye_n), .o_cycles(cyc),
    .o_accesses(acc), .o_total_time(tot));
  eic_ext_decoder u_far (.i_mclk(clk), .i_upper_addr(addr), .i_bit_io_strobe(stb),
    .o_code(code), .o_hits(hits));
  initial forever #4 clk = ~clk;
  task automatic print_verdict();
    $display("checks %0d, errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----
  // One instruction or request, timed
  // ----
  task automatic go(input logic [15:0] i, input logic [2:0] r, input logic [7:0] c,
                    input logic [3:0] m, input logic [7:0] s);
    int n, k;
    logic last;
    logic [7:0] h;
    h = hits;
    @(posedge clk);
    ins <= i;
    vld <= ~|r;
    {rrq, lrq, irq} <= r;
    @(posedge clk);
    vld <= 1'b0;
    {rrq, lrq, irq} <= 3'h0;
    n = 0;
    k = 0;
    last = 1'b1;
    @(negedge clk);
    while (!rdy && !idle && n < 400) begin
      n++;
      k += !cye_n;
      last = cye_n;
      @(negedge clk);
    end
    `CHK(n, 32'(c) + 32'(ws) * 32'(m))
    `CHK(k, 1)
    `CHK(last, 1'b0)
    `CHK(cyc, c)
    `CHK(acc, m)
    `CHK(tot, 12'(c) + 12'(ws) * 12'(m))
    `CHK(hits - h, s)
  endtask
  task automatic t_ext();
    logic [10:0] op [4];
    logic [2:0] cd [4];
    op = '{OP_MASK_CLEAR, OP_USER_HHL, OP_USER_HLH, OP_USER_HHH};
    cd = '{CODE_MASK_CLEAR, CODE_USER_HHL, CODE_USER_HLH, CODE_USER_HHH};
    for (int j = 0; j < 4; j++) begin
      go({op[j], 5'h00}, 3'h0, C_EXT, M_EXT, 8'h01);
      `CHK(code, cd[j])
      `CHK(addr, cd[j])
    end
  endtask
  task automatic t_mask();
    @(posedge clk);
    imm <= 16'hFFFA;
    go({OP_MASK_LOAD, 5'h00}, 3'h0, 8'h0E, 4'h2, 8'h00);
    `CHK(st, 16'h000A)
    go({OP_MASK_CLEAR, 5'h00}, 3'h0, C_EXT, M_EXT, 8'h01);
    `CHK(st[3:0], 4'h0)
  endtask
  task automatic t_div();
    @(posedge clk);
    dov <= 1'b1;
    go(16'h3C10, 3'h0, 8'h14, 4'h4, 8'h00);
    `CHK(st[11], 1'b1)
    @(posedge clk);
    dov <= 1'b0;
    dcy <= 8'h7C;
    go(16'h3C00, 3'h0, 8'h7C, 4'h6, 8'h00);
    `CHK(st[11], 1'b0)
    @(posedge clk);
    xi <= 1'b1;
    go({OP_MASK_LOAD, 5'h00}, 3'h0, 8'h0A, 4'h1, 8'h00);
    @(posedge clk);
    xi <= 1'b0;
  endtask
  task automatic t_undef_ctx();
    logic [15:0] s0;
    s0 = st;
    go(16'h0000, 3'h0, C_UNDEF, M_UNDEF, 8'h00);
    go(16'h0C00, 3'h0, C_UNDEF, M_UNDEF, 8'h00);
    `CHK(st, s0)
    go(16'h0000, 3'h2, C_CTX, M_CTX, 8'h00);
    go(16'h0000, 3'h4, C_RESET, M_RESET, 8'h00);
    `CHK(st, ST_RESET)
  endtask
  task automatic t_idle();
    logic [15:0] s0;
    int n;
    s0 = st;
    go({OP_IDLE, 5'h00}, 3'h0, C_EXT, M_EXT, 8'h01);
    `CHK(code, CODE_IDLE)
    @(posedge clk);
    ins <= {OP_USER_HHH, 5'h00};
    vld <= 1'b1;
    repeat (10) @(posedge clk);
    vld <= 1'b0;
    irq <= 1'b1;
    `CHK(idle, 1'b1)
    `CHK(st, s0)
    `CHK(code, CODE_IDLE)
    n = 0;
    while (idle && n < 50) begin
      n++;
      @(negedge clk);
    end
    @(posedge clk);
    irq <= 1'b0;
    @(negedge clk);
    while (!rdy && n < 200) begin
      n++;
      @(negedge clk);
    end
    `CHK(idle, 1'b0)
    `CHK(cyc, C_CTX)
    `CHK(acc, M_CTX)
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_ext();
    t_mask();
    t_div();
    t_undef_ctx();
    t_idle();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict();
  end
endmodule
